// ---- hw/pump_stepper.sv ----
// charge pump current step-down sequencer run after oscillator calibration
`timescale 1ns/1ps
module pump_stepper #(
    parameter int CUR_W = 4,
    parameter int CNT_W = 9
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             load,
    input  wire logic [CUR_W-1:0] begin_cur,
    input  wire logic [CUR_W-1:0] end_cur,
    input  wire logic [1:0]       step_sel,
    // result
    output logic      [CUR_W-1:0] current
);
    import synth_cal_pkg::*;

    typedef struct packed {
        logic [CUR_W-1:0] cur;
        logic             active;
        logic [CNT_W-1:0] cnt;
    } step_t;

    step_t st;
    step_t next_st;

    function automatic logic [CNT_W-1:0] reload(input logic [1:0] sel);
        case (sel)
            2'h0:    reload = CNT_W'(STEP0_CYC - 1);
            2'h1:    reload = CNT_W'(STEP1_CYC - 1);
            2'h2:    reload = CNT_W'(STEP2_CYC - 1);
            default: reload = CNT_W'(STEP3_CYC - 1);
        endcase
    endfunction

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.cur    = begin_cur;
            // no stepping unless begin above end
            next_st.active = begin_cur > end_cur;
            next_st.cnt    = reload(step_sel);
        end else if (st.active) begin
            if (st.cnt == '0) begin
                next_st.cur = st.cur - 1'b1;
                next_st.cnt = reload(step_sel);
                // end value may be rewritten mid-sequence, so stop on reaching or passing it
                if (st.cur - 1'b1 <= end_cur) begin
                    next_st.active = 1'b0;
                end
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{cur: PUMP_RST, active: 1'b0, cnt: '0};
        end else begin
            st <= next_st;
        end
    end

    assign current = st.cur;

    chk_step_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        load |=> current == $past(begin_cur))
        else $error("pump current not loaded from begin value");

    chk_step_size: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!load && !$past(load) && $changed(current)) |-> current == $past(current) - 1'b1)
        else $error("pump current stepped by other than one code");
endmodule

// ---- hw/synth_cal_regs.sv ----
// synthesizer and receive filter calibration test register bank
`timescale 1ns/1ps
module synth_cal_regs #(
    parameter int CAL_SHORT_CYCLES = synth_cal_pkg::CAL_SHORT_CYC,
    parameter int CAL_LONG_CYCLES  = synth_cal_pkg::CAL_LONG_CYC,
    parameter int CAL_CNT_W        = 13
) (
    // clock and reset
    input  wire logic                                sys_clk,
    input  wire logic                                rst_n,
    // register port from the serial configuration logic
    input  wire logic [synth_cal_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic                                reg_wr,
    input  wire logic [synth_cal_pkg::DATA_W-1:0]    reg_wdata,
    output logic      [synth_cal_pkg::DATA_W-1:0]    reg_rdata,
    // radio state events
    input  wire logic                                rx_entry,
    input  wire logic                                tx_entry,
    input  wire logic                                cal_transmit_strobe,
    input  wire logic                                tune_node_test_input,
    // calibration results from the analog section
    input  wire logic [synth_cal_pkg::A_W-1:0]       osc_current_cal_code,
    input  wire logic                                filter_cap_cal_valid,
    input  wire logic [synth_cal_pkg::CAP_W-1:0]     filter_cap_cal_code,
    // phase detector pulses
    input  wire logic                                pd_up,
    input  wire logic                                pd_down,
    // oscillator calibration control
    output logic                                     osc_cal_start,
    output logic                                     osc_cal_busy,
    output logic                                     osc_cal_done,
    output logic                                     long_freq_measure,
    output logic      [synth_cal_pkg::TARGET_W-1:0]  osc_current_target,
    output logic      [synth_cal_pkg::B_W-1:0]       osc_current_b_value,
    output logic      [synth_cal_pkg::RATE_W-1:0]    osc_current_cal_rate,
    output logic      [synth_cal_pkg::A_W-1:0]       osc_current_a_drive,
    // tuning node
    output logic                                     tune_from_dac,
    output logic      [synth_cal_pkg::TUNE_W-1:0]    tune_dac_value,
    // charge pump and phase detector
    output logic                                     pump_up,
    output logic                                     pump_down,
    output logic                                     phase_det_reset_delay,
    output logic      [synth_cal_pkg::PUMP_W-1:0]    pump_current,
    // receive filter
    output logic      [synth_cal_pkg::CAP_W-1:0]     rx_filter_cap
);
    import synth_cal_pkg::*;

    typedef struct packed {
        logic                 skip_tx;
        logic                 long_meas;
        logic [TARGET_W-1:0]  target;
        logic [B_W-1:0]       b_value;
        logic                 tune_sel;
        logic [TUNE_W-1:0]    tune_val;
        logic [RATE_W-1:0]    rate;
        logic                 osc_oe;
        logic [A_W-1:0]       a_value;
        logic [A_W-1:0]       osc_res;
        logic                 pump_off_cal;
        logic                 pump_oe;
        logic                 force_up;
        logic                 force_dn;
        logic                 mask;
        logic                 pd_long;
        logic [STEP_W-1:0]    step_sel;
        logic [PUMP_W-1:0]    end_cur;
        logic [PUMP_W-1:0]    begin_cur;
        logic                 cap_oe;
        logic [CAP_W-1:0]     cap_ov;
        logic [CAP_W-1:0]     cap_res;
        cal_state_t           cal;
        logic                 cal_long;
        logic [CAL_CNT_W-1:0] cal_cnt;
        logic [DATA_W-1:0]    rdata;
        logic                 cal_start;
        logic                 cal_busy;
        logic                 cal_done;
        logic [A_W-1:0]       a_drive;
        logic                 from_dac;
        logic                 up;
        logic                 dn;
        logic [PUMP_W-1:0]    pump_cur;
        logic [CAP_W-1:0]     cap_drive;
    } state_t;

    state_t             st;
    state_t             next_st;
    logic [PUMP_W-1:0]  step_cur;
    logic               trigger;
    logic               cal_hold;
    logic [CAL_CNT_W-1:0] h_len;

    // reserved bits read as zero
    function automatic logic [DATA_W-1:0] read_word(input state_t s,
                                                    input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = '0;
        case (a)
            ADDR_CAL_CONTROL: begin
                w[SKIP_TX_BIT]                = s.skip_tx;
                w[LONG_BIT]                   = s.long_meas;
                w[TARGET_LSB +: TARGET_W]     = s.target;
                w[B_LSB +: B_W]               = s.b_value;
                w[TUNE_SEL_BIT]               = s.tune_sel;
                w[TUNE_LSB +: TUNE_W]         = s.tune_val;
            end
            ADDR_CURRENT_CAL: begin
                w[RATE_LSB +: RATE_W]         = s.rate;
                w[OSC_OE_BIT]                 = s.osc_oe;
                w[A_LSB +: A_W]               = s.a_value;
                w[RES_LSB +: A_W]             = s.osc_res;
            end
            ADDR_PUMP_CTRL: begin
                w[OFF_CAL_BIT]                = s.pump_off_cal;
                w[PUMP_OE_BIT]                = s.pump_oe;
                w[UP_BIT]                     = s.force_up;
                w[DN_BIT]                     = s.force_dn;
                w[MASK_BIT]                   = s.mask;
                w[PHASE_DET_RESET_DELAY_BIT]               = s.pd_long;
                w[STEP_LSB +: STEP_W]         = s.step_sel;
                w[END_LSB +: PUMP_W]          = s.end_cur;
                w[BEGIN_LSB +: PUMP_W]        = s.begin_cur;
            end
            ADDR_FILTER_CAP: begin
                w[CAP_OE_BIT]                 = s.cap_oe;
                w[CAP_OV_LSB +: CAP_W]        = s.cap_ov;
                w[CAP_RES_LSB +: CAP_W]       = s.cap_res;
            end
            default: w = '0;
        endcase
        return w;
    endfunction

    pump_stepper #(
        .CUR_W (PUMP_W),
        .CNT_W (9)
    ) u_stepper (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .load      (st.cal_done),
        .begin_cur (st.begin_cur),
        .end_cur   (st.end_cur),
        .step_sel  (st.step_sel),
        .current   (step_cur)
    );

    assign trigger = rx_entry | cal_transmit_strobe | (tx_entry & ~st.skip_tx);
    assign cal_hold = st.pump_off_cal & st.cal_busy;

    always_comb begin
        next_st           = st;
        next_st.cal_start = 1'b0;
        next_st.cal_done  = 1'b0;
        next_st.rdata     = read_word(st, reg_addr);

        // result fields have no write path; reserved bits dropped
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CAL_CONTROL: begin
                    next_st.skip_tx   = reg_wdata[SKIP_TX_BIT];
                    next_st.long_meas = reg_wdata[LONG_BIT];
                    next_st.target    = reg_wdata[TARGET_LSB +: TARGET_W];
                    next_st.b_value   = reg_wdata[B_LSB +: B_W];
                    next_st.tune_sel  = reg_wdata[TUNE_SEL_BIT];
                    next_st.tune_val  = reg_wdata[TUNE_LSB +: TUNE_W];
                end
                ADDR_CURRENT_CAL: begin
                    next_st.rate      = reg_wdata[RATE_LSB +: RATE_W];
                    next_st.osc_oe    = reg_wdata[OSC_OE_BIT];
                    next_st.a_value   = reg_wdata[A_LSB +: A_W];
                end
                ADDR_PUMP_CTRL: begin
                    next_st.pump_off_cal = reg_wdata[OFF_CAL_BIT];
                    next_st.pump_oe      = reg_wdata[PUMP_OE_BIT];
                    next_st.force_up     = reg_wdata[UP_BIT];
                    next_st.force_dn     = reg_wdata[DN_BIT];
                    next_st.mask         = reg_wdata[MASK_BIT];
                    next_st.pd_long      = reg_wdata[PHASE_DET_RESET_DELAY_BIT];
                    next_st.step_sel     = reg_wdata[STEP_LSB +: STEP_W];
                    next_st.end_cur      = reg_wdata[END_LSB +: PUMP_W];
                    next_st.begin_cur    = reg_wdata[BEGIN_LSB +: PUMP_W];
                end
                ADDR_FILTER_CAP: begin
                    next_st.cap_oe    = reg_wdata[CAP_OE_BIT];
                    next_st.cap_ov    = reg_wdata[CAP_OV_LSB +: CAP_W];
                end
                default: begin
                    next_st.cap_oe    = st.cap_oe;
                end
            endcase
        end

        if (filter_cap_cal_valid) begin
            next_st.cap_res = filter_cap_cal_code;
        end

        case (st.cal)
            CAL_IDLE: begin
                // triggers during a running calibration are absorbed, not queued
                if (trigger) begin
                    next_st.cal       = CAL_RUN;
                    next_st.cal_start = 1'b1;
                    next_st.cal_busy  = 1'b1;
                    next_st.cal_long  = st.long_meas;
                    next_st.cal_cnt   = st.long_meas ? CAL_CNT_W'(CAL_LONG_CYCLES - 1)
                                                     : CAL_CNT_W'(CAL_SHORT_CYCLES - 1);
                end
            end
            CAL_RUN: begin
                if (st.cal_cnt == '0) begin
                    next_st.cal      = CAL_IDLE;
                    next_st.cal_busy = 1'b0;
                    next_st.cal_done = 1'b1;
                    next_st.osc_res  = osc_current_cal_code;
                end else begin
                    next_st.cal_cnt  = st.cal_cnt - 1'b1;
                end
            end
            default: begin
                next_st.cal      = CAL_IDLE;
                next_st.cal_busy = 1'b0;
            end
        endcase

        next_st.a_drive   = st.osc_oe ? st.a_value : st.osc_res;
        next_st.from_dac  = st.tune_sel & ~tune_node_test_input;
        // force beats mask; hold tracks next busy, so the first busy cycle is quiet
        next_st.up        = ~(next_st.pump_off_cal & next_st.cal_busy)
                            & (st.force_up | (pd_up & ~st.mask));
        next_st.dn        = ~(next_st.pump_off_cal & next_st.cal_busy)
                            & (st.force_dn | (pd_down & ~st.mask));
        next_st.pump_cur  = st.pump_oe ? st.begin_cur : step_cur;
        next_st.cap_drive = st.cap_oe ? st.cap_ov : st.cap_res;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st              <= '0;
            st.long_meas    <= 1'b1;
            st.target       <= TARGET_RST;
            st.tune_val     <= TUNE_RST;
            st.a_value      <= A_RST;
            st.osc_res      <= RES_RST;
            st.pump_off_cal <= 1'b1;
            st.step_sel     <= STEP_RST;
            st.end_cur      <= PUMP_RST;
            st.begin_cur    <= PUMP_RST;
            st.cal          <= CAL_IDLE;
            st.a_drive      <= RES_RST;
            st.pump_cur     <= PUMP_RST;
        end else begin
            st <= next_st;
        end
    end

    assign long_freq_measure     = st.long_meas;
    assign osc_current_target    = st.target;
    assign osc_current_b_value   = st.b_value;
    assign osc_current_cal_rate  = st.rate;
    assign phase_det_reset_delay = st.pd_long;
    assign tune_dac_value        = st.tune_val;
    assign reg_rdata             = st.rdata;
    assign osc_cal_start         = st.cal_start;
    assign osc_cal_busy          = st.cal_busy;
    assign osc_cal_done          = st.cal_done;
    assign osc_current_a_drive   = st.a_drive;
    assign tune_from_dac         = st.from_dac;
    assign pump_up               = st.up;
    assign pump_down             = st.dn;
    assign pump_current          = st.pump_cur;
    assign rx_filter_cap         = st.cap_drive;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_len <= '0;
        end else begin
            h_len <= st.cal_busy ? h_len + 1'b1 : '0;
        end
    end

    chk_tx_skip: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st.cal == CAL_IDLE && tx_entry && !rx_entry && !cal_transmit_strobe)
        |=> osc_cal_start == !$past(st.skip_tx))
        else $error("transmit entry calibration wrong for skip setting");

    chk_cal_length: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(osc_cal_busy) |-> h_len == CAL_CNT_W'(st.cal_long ? CAL_LONG_CYCLES
                                                               : CAL_SHORT_CYCLES))
        else $error("calibration duration wrong");

    chk_result_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(osc_cal_done) |-> st.osc_res == $past(osc_current_cal_code))
        else $error("current result not captured at calibration end");

    chk_osc_override: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st.osc_oe && $stable(st.a_value)) |=> osc_current_a_drive == $past(st.a_value))
        else $error("current override value not applied");

    chk_pump_cal_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (osc_cal_busy && st.pump_off_cal) |-> (!pump_up && !pump_down))
        else $error("charge pump active during calibration");

    chk_pump_mask: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st.mask && !st.force_up && !st.force_dn) |=> (!pump_up && !pump_down))
        else $error("masked pump passed detector pulse");

    chk_force_up: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st.force_up && !cal_hold) [*2] |-> pump_up)
        else $error("forced up current not output");

    chk_tune_source: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tune_node_test_input || !st.tune_sel) |=> !tune_from_dac)
        else $error("tune dac selected while closed loop or test input");

    chk_filter_override: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!st.cap_oe && $stable(st.cap_res)) |=> rx_filter_cap == $past(st.cap_res))
        else $error("filter override applied while disabled");
endmodule

// ---- shared/synth_cal_pkg.sv ----
// constants and types shared by the synthesizer calibration register bank
package synth_cal_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_CAL_CONTROL = 6'h28;
    localparam logic [ADDR_W-1:0] ADDR_CURRENT_CAL = 6'h29;
    localparam logic [ADDR_W-1:0] ADDR_PUMP_CTRL   = 6'h2A;
    localparam logic [ADDR_W-1:0] ADDR_FILTER_CAP  = 6'h2B;
    // synth_cal_control fields
    localparam int SKIP_TX_BIT  = 15;
    localparam int LONG_BIT     = 14;
    localparam int TARGET_LSB   = 10;
    localparam int TARGET_W     = 4;
    localparam int B_LSB        = 4;
    localparam int B_W          = 6;
    localparam int TUNE_SEL_BIT = 3;
    localparam int TUNE_LSB     = 0;
    localparam int TUNE_W       = 3;
    // synth_current_cal fields
    localparam int RATE_LSB     = 13;
    localparam int RATE_W       = 2;
    localparam int OSC_OE_BIT   = 12;
    localparam int A_LSB        = 6;
    localparam int A_W          = 6;
    localparam int RES_LSB      = 0;
    // charge_pump_control fields
    localparam int OFF_CAL_BIT  = 15;
    localparam int PUMP_OE_BIT  = 14;
    localparam int UP_BIT       = 13;
    localparam int DN_BIT       = 12;
    localparam int MASK_BIT     = 11;
    localparam int PHASE_DET_RESET_DELAY_BIT = 10;
    localparam int STEP_LSB     = 8;
    localparam int STEP_W       = 2;
    localparam int END_LSB      = 4;
    localparam int BEGIN_LSB    = 0;
    localparam int PUMP_W       = 4;
    // rx_filter_cap_cal fields
    localparam int CAP_OE_BIT   = 14;
    localparam int CAP_OV_LSB   = 7;
    localparam int CAP_W        = 7;
    localparam int CAP_RES_LSB  = 0;
    // reset values
    localparam logic [TARGET_W-1:0] TARGET_RST = 4'h4;
    localparam logic [TUNE_W-1:0]   TUNE_RST   = 3'h2;
    localparam logic [A_W-1:0]      A_RST      = 6'h18;
    localparam logic [A_W-1:0]      RES_RST    = 6'h20;
    localparam logic [STEP_W-1:0]   STEP_RST   = 2'h2;
    localparam logic [PUMP_W-1:0]   PUMP_RST   = 4'hD;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_SHORT_US  = 37;
    localparam int CAL_LONG_US   = 57;
    localparam int CAL_SHORT_CYC = CAL_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int CAL_LONG_CYC  = CAL_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int STEP0_NS      = 250;
    localparam int STEP1_NS      = 500;
    localparam int STEP2_NS      = 1000;
    localparam int STEP3_NS      = 4000;
    localparam int STEP0_CYC     = STEP0_NS / CLK_PERIOD_NS;
    localparam int STEP1_CYC     = STEP1_NS / CLK_PERIOD_NS;
    localparam int STEP2_CYC     = STEP2_NS / CLK_PERIOD_NS;
    localparam int STEP3_CYC     = STEP3_NS / CLK_PERIOD_NS;
    typedef enum logic {CAL_IDLE = 1'b0, CAL_RUN = 1'b1} cal_state_t;
endpackage

// ---- verification/tb.sv ----
// self-checking bench for the calibration test register bank
`timescale 1ns/1ps
module tb;
    import synth_cal_pkg::*;
    logic sys_clk, rst_n, reg_wr, rx_entry, tx_entry, strobe, tni, cap_v, pd_up, pd_down;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [A_W-1:0]    osc_code, a_drv;
    logic [CAP_W-1:0]  cap_code, rx_cap;
    logic start, busy, done, up, dn, tsel;
    logic [PUMP_W-1:0] pcur;
    logic [TUNE_W-1:0] tval;
    logic lfm, pdd;
    logic [TARGET_W-1:0] tgt;
    logic [B_W-1:0]      bval;
    logic [RATE_W-1:0]   rate;
    int n_fail, samples_checked, cyc, n;
    // short calibration counts keep the run brief
    synth_cal_regs #(.CAL_SHORT_CYCLES(20), .CAL_LONG_CYCLES(30), .CAL_CNT_W(13)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_entry(rx_entry),
        .tx_entry(tx_entry), .cal_transmit_strobe(strobe), .tune_node_test_input(tni),
        .osc_current_cal_code(osc_code), .filter_cap_cal_valid(cap_v),
        .filter_cap_cal_code(cap_code), .pd_up(pd_up), .pd_down(pd_down),
        .osc_cal_start(start), .osc_cal_busy(busy), .osc_cal_done(done),
        .long_freq_measure(lfm), .osc_current_target(tgt), .osc_current_b_value(bval),
        .osc_current_cal_rate(rate), .osc_current_a_drive(a_drv), .tune_from_dac(tsel),
        .tune_dac_value(tval), .pump_up(up), .pump_down(dn), .phase_det_reset_delay(pdd),
        .pump_current(pcur), .rx_filter_cap(rx_cap));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        // ceiling well above the few hundred cycles the scenarios need
        if (cyc > 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a; reg_wr = 1'b1; reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        chk(reg_rdata, e, "read");
    endtask
    // pulse an event, then measure the busy window
    task automatic cal(input int ev, input int exp_len);
        @(negedge sys_clk);
        if (ev == 0) rx_entry = 1'b1;
        else if (ev == 1) strobe = 1'b1;
        else tx_entry = 1'b1;
        @(negedge sys_clk);
        rx_entry = 1'b0; strobe = 1'b0; tx_entry = 1'b0;
        chk({start, busy}, 2'b11, "cal start");
        n = 1;
        forever begin
            @(negedge sys_clk);
            if (!busy) break;
            n++;
        end
        chk(n, exp_len, "busy length");
        chk(done, 1'b1, "done pulse");
    endtask
    task automatic t_reset();
        rd(ADDR_CAL_CONTROL, 16'h5002);
        rd(ADDR_CURRENT_CAL, 16'h0620);
        rd(ADDR_PUMP_CTRL, 16'h82DD);
        rd(ADDR_FILTER_CAP, 16'h0000);
        rd(6'h30, 16'h0000);
        chk(lfm, 1'b1, "long reset");
        chk(tgt, 4'h4, "target reset");
        chk(a_drv, 6'h20, "result reset");
        chk(pcur, 4'hD, "pump reset");
    endtask
    task automatic t_cal();
        osc_code = 6'h2A;
        cal(0, 30);
        rd(ADDR_CURRENT_CAL, 16'h062A);
        chk(a_drv, 6'h2A, "a drive");
        wr(ADDR_CURRENT_CAL, 16'h1415);
        rd(ADDR_CURRENT_CAL, 16'h142A);
        chk(a_drv, 6'h10, "a override");
        wr(ADDR_CAL_CONTROL, 16'h8000);
        chk(lfm, 1'b0, "long cleared");
        tx_entry = 1'b1;
        @(negedge sys_clk);
        tx_entry = 1'b0;
        @(negedge sys_clk);
        chk(busy, 1'b0, "skip tx");
        cal(1, 20);
        wr(ADDR_CAL_CONTROL, 16'h0000);
        cal(2, 20);
    endtask
    task automatic t_pump();
        pd_up = 1'b1;
        wr(ADDR_PUMP_CTRL, 16'h0800);
        @(negedge sys_clk);
        chk(up, 1'b0, "mask");
        wr(ADDR_PUMP_CTRL, 16'h2800);
        @(negedge sys_clk);
        chk({up, dn}, 2'b10, "force up");
        wr(ADDR_PUMP_CTRL, 16'h1000);
        @(negedge sys_clk);
        chk({up, dn}, 2'b11, "force down");
        wr(ADDR_PUMP_CTRL, 16'h4007);
        @(negedge sys_clk);
        chk(pcur, 4'h7, "pump override");
        wr(ADDR_PUMP_CTRL, 16'h8035);
        rx_entry = 1'b1;
        @(negedge sys_clk);
        rx_entry = 1'b0;
        chk({up, dn}, 2'b00, "pump off in cal");
        while (!done) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
        chk(pcur, 4'h5, "begin");
        repeat (24) @(negedge sys_clk);
        chk(pcur, 4'h5, "before step");
        @(negedge sys_clk);
        chk(pcur, 4'h4, "step");
        repeat (75) @(negedge sys_clk);
        chk(pcur, 4'h3, "end hold");
    endtask
    task automatic t_misc();
        wr(ADDR_CAL_CONTROL, 16'h2EAD);
        @(negedge sys_clk);
        chk({tsel, tval}, 4'hD, "tune dac");
        chk(tgt, 4'hB, "target");
        chk(bval, 6'h2A, "b value");
        tni = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(tsel, 1'b0, "tune test");
        wr(ADDR_CURRENT_CAL, 16'h4000);
        chk(rate, 2'h2, "cal rate");
        @(negedge sys_clk);
        chk(a_drv, 6'h2A, "override off");
        wr(ADDR_PUMP_CTRL, 16'h0400);
        chk(pdd, 1'b1, "phase_det_reset_delay");
        wr(ADDR_FILTER_CAP, 16'h2A80);
        cap_code = 7'h11; cap_v = 1'b1;
        @(negedge sys_clk);
        cap_v = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(rx_cap, 7'h11, "cap result");
        wr(ADDR_FILTER_CAP, 16'h6AFF);
        rd(ADDR_FILTER_CAP, 16'h6A91);
        chk(rx_cap, 7'h55, "cap override");
    endtask
    initial begin
        {rst_n, reg_wr, rx_entry, tx_entry, strobe, tni, cap_v, pd_up, pd_down} = '0;
        reg_addr = '0; reg_wdata = '0; osc_code = '0; cap_code = '0;
        n_fail = 0; samples_checked = 0; cyc = 0;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_cal();
        t_pump();
        t_misc();
        final_report();
    end
endmodule
